// ===== hw/pw_contact.sv
// Debounce and pulse-width timing for one active-low contact input
`timescale 1ns/1ps
module pw_contact (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic tick_ms,
	input wire logic enable,
	input wire logic contact_b,
	output pw_pkg::pw_contact_ev_s ev
);
	import pw_pkg::*;

	logic pressed_reg;
	logic armed_reg;
	logic [MS_CNT_W-1:0] lvl_cnt_reg;
	logic [MS_CNT_W-1:0] hold_cnt_reg;
	logic [MS_CNT_W-1:0] idle_cnt_reg;

	// Pins are ignored until enabled; a disabled pin reads as released
	wire raw_low = enable && !contact_b;
	wire differs = (raw_low != pressed_reg);
	// Level must differ for more than 1 ms, which merges short gaps too
	wire flip = tick_ms && differs && (lvl_cnt_reg == MS_CNT_W'(PULSE_MIN_MS));
	wire press = flip && !pressed_reg;
	wire hold_hit = (hold_cnt_reg == MS_CNT_W'(HOLD_MS - 1));
	wire repeat_hit = tick_ms && pressed_reg && !flip && hold_hit;
	wire idle_hit = tick_ms && armed_reg && !pressed_reg && (idle_cnt_reg == MS_CNT_W'(REVERSE_MS - 1));

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pressed_reg <= 1'b0;
			armed_reg <= 1'b0;
			lvl_cnt_reg <= '0;
			hold_cnt_reg <= '0;
			idle_cnt_reg <= '0;
			ev <= '0;
		end
		else
		begin
			ev.step <= press || repeat_hit;
			ev.idle <= idle_hit;
			ev.pressed <= pressed_reg;
			if (!differs)
				lvl_cnt_reg <= '0;
			else if (tick_ms)
				lvl_cnt_reg <= flip ? '0 : lvl_cnt_reg + 1'b1;
			if (flip)
				pressed_reg <= !pressed_reg;
			if (press)
				armed_reg <= 1'b1;
			else if (idle_hit)
				armed_reg <= 1'b0;
			// auto-repeat timing
			// After the first second, jump back so the next step comes 100 ms later
			if (!pressed_reg)
				hold_cnt_reg <= '0;
			else if (repeat_hit)
				hold_cnt_reg <= MS_CNT_W'(HOLD_MS - REPEAT_MS);
			else if (tick_ms)
				hold_cnt_reg <= hold_cnt_reg + 1'b1;
			if (pressed_reg || idle_hit)
				idle_cnt_reg <= '0;
			else if (tick_ms && armed_reg)
				idle_cnt_reg <= idle_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step pulses last one cycle
	a_step_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
		ev.step |=> !ev.step)
		else $error("step pulse lasted more than one cycle");
	a_gap_merge: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(pressed_reg && !(tick_ms && lvl_cnt_reg == MS_CNT_W'(GAP_MIN_MS))) |=> pressed_reg)
		else $error("contact released without a full gap");

endmodule : pw_contact

// ===== hw/pw_ms_tick.sv
// One millisecond enable pulse from the system clock
`timescale 1ns/1ps
module pw_ms_tick #(
	parameter int CYCLES_PER_MS = 200000
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	output logic tick_ms
);
	import pw_pkg::*;

	localparam int CW = $clog2(CYCLES_PER_MS);

	initial begin
		if (CYCLES_PER_MS < 2)
			$error("pw_ms_tick needs at least two cycles per tick");
	end

	logic [CW-1:0] cnt_reg;
	wire last = (cnt_reg == CW'(CYCLES_PER_MS - 1));

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_reg <= '0;
			tick_ms <= 1'b0;
		end
		else
		begin
			cnt_reg <= last ? '0 : cnt_reg + 1'b1;
			tick_ms <= last;
		end
	end

endmodule : pw_ms_tick

// ===== hw/pw_wiper_ctrl.sv
// Pushbutton control of two wiper position counters
`timescale 1ns/1ps
module pw_wiper_ctrl #(
	parameter int CYCLES_PER_MS = pw_pkg::CYCLES_PER_MS
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [pw_pkg::NUM_PINS-1:0] contact_b,
	input wire logic mode_independent,
	input wire logic single_button_sel,
	output pw_pkg::pw_wipers_s wipers_reg,
	output logic serial_ready_reg,
	output logic contacts_active_reg,
	output logic stereo_mode_reg,
	output logic single_mode_reg
);
	import pw_pkg::*;

	initial begin
		if (CYCLES_PER_MS < 2)
			$error("pw_wiper_ctrl needs at least two cycles per millisecond");
	end

	////////////////////////////////////////////////////////////////////////////
	// Time base and power-up sequencing
	logic tick_ms;
	pw_phase_e phase_reg;
	logic strap_taken_reg;
	logic [$clog2(SERIAL_READY_CYCLES+1)-1:0] ready_cnt_reg;
	logic [MS_CNT_W-1:0] pwr_ms_reg;

	pw_ms_tick #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_tick (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.tick_ms(tick_ms)
	);

	wire ready_done = (ready_cnt_reg == ($bits(ready_cnt_reg))'(SERIAL_READY_CYCLES - 1));
	wire pwr_done = tick_ms && (pwr_ms_reg == MS_CNT_W'(POWERUP_MS - 1));

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase_reg <= PW_POWERUP;
			ready_cnt_reg <= '0;
			pwr_ms_reg <= '0;
			serial_ready_reg <= 1'b0;
			contacts_active_reg <= 1'b0;
			strap_taken_reg <= 1'b0;
			stereo_mode_reg <= 1'b0;
			single_mode_reg <= 1'b0;
		end
		else
		begin
			if (!serial_ready_reg)
				ready_cnt_reg <= ready_cnt_reg + 1'b1;
			if (ready_done)
				serial_ready_reg <= 1'b1;
			if (phase_reg == PW_POWERUP && tick_ms)
				pwr_ms_reg <= pwr_ms_reg + 1'b1;
			if (phase_reg == PW_POWERUP && pwr_done)
			begin
				phase_reg <= PW_ACTIVE;
				contacts_active_reg <= 1'b1;
			end
			if (!strap_taken_reg)
			begin
				strap_taken_reg <= 1'b1;
				stereo_mode_reg <= !mode_independent;
				single_mode_reg <= single_button_sel;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Contact conditioning
	pw_contact_ev_s ev [NUM_PINS];

	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		pw_contact u_contact (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.tick_ms(tick_ms),
			.enable(contacts_active_reg),
			.contact_b(contact_b[i]),
			.ev(ev[i])
		);
	end

	// Shared pins read under their independent or stereo meaning
	wire up_contact_ch_zero = ev[PIN_UP0_RAISE].step;
	wire down_contact_ch_zero = ev[PIN_DN0_LOWER].step;
	wire up_contact_ch_one = ev[PIN_UP1_BAL0].step;
	wire down_contact_ch_one = ev[PIN_DN1_BAL1].step;
	wire volume_raise_contact = ev[PIN_UP0_RAISE].step;
	wire volume_lower_contact = ev[PIN_DN0_LOWER].step;
	wire balance_zero_contact = ev[PIN_UP1_BAL0].step;
	wire balance_one_contact = ev[PIN_DN1_BAL1].step;
	wire idle_pin0 = ev[PIN_UP0_RAISE].idle;
	wire idle_pin2 = ev[PIN_UP1_BAL0].idle;

	////////////////////////////////////////////////////////////////////////////
	// Movement requests
	// dir bit set means toward the high end (position decreasing)
	logic [1:0] dir_reg;
	logic [1:0] dir_next;
	logic bal_seen_reg;
	logic bal_seen_next;
	pw_pos_t bal_ref_reg;
	pw_pos_t bal_ref_next;
	pw_wipers_s wipers_next;

	wire pw_pos_t pos0 = wipers_reg.pos0;
	wire pw_pos_t pos1 = wipers_reg.pos1;
	wire active = (phase_reg == PW_ACTIVE);
	wire indep = active && !stereo_mode_reg;
	wire stereo = active && stereo_mode_reg;

	wire ch0_up = indep && (single_mode_reg ? (up_contact_ch_zero && dir_reg[0]) :
		(up_contact_ch_zero && !down_contact_ch_zero));
	wire ch0_dn = indep && (single_mode_reg ? (up_contact_ch_zero && !dir_reg[0]) :
		(down_contact_ch_zero && !up_contact_ch_zero));
	wire ch1_up = indep && (single_mode_reg ? (up_contact_ch_one && dir_reg[1]) :
		(up_contact_ch_one && !down_contact_ch_one));
	wire ch1_dn = indep && (single_mode_reg ? (up_contact_ch_one && !dir_reg[1]) :
		(down_contact_ch_one && !up_contact_ch_one));
	wire vol_up = stereo && (single_mode_reg ? (volume_raise_contact && dir_reg[0]) :
		(volume_raise_contact && !volume_lower_contact));
	wire vol_dn = stereo && (single_mode_reg ? (volume_raise_contact && !dir_reg[0]) :
		(volume_lower_contact && !volume_raise_contact));
	// In single-button stereo the balance side alternates after a quiet second
	wire bal0 = stereo && !vol_up && !vol_dn && (single_mode_reg ?
		(balance_zero_contact && !dir_reg[1]) : (balance_zero_contact && !balance_one_contact));
	wire bal1 = stereo && !vol_up && !vol_dn && (single_mode_reg ?
		(balance_zero_contact && dir_reg[1]) : (balance_one_contact && !balance_zero_contact));

	wire vol_up_ok = (pos0 != POS_HIGH_END) && (pos1 != POS_HIGH_END);
	wire vol_dn_ok = (pos0 != POS_MUTE) && (pos1 != POS_MUTE);
	wire both_low = (pos0 == POS_LOW) && (pos1 == POS_LOW);
	wire pw_pos_t nearer_high = (pos0 < pos1) ? pos0 : pos1;

	function automatic pw_pos_t pw_move(pw_pos_t p, logic up, logic dn);
		pw_pos_t r;
		r = p;
		if (up && p != POS_HIGH_END)
			r = p - 1'b1;
		else if (dn && p != POS_MUTE)
			r = p + 1'b1;
		return r;
	endfunction : pw_move

	function automatic logic pw_end_dir(pw_pos_t p, logic d);
		logic r;
		r = d;
		if (p == POS_HIGH_END)
			r = 1'b0;
		else if (p == POS_MUTE)
			r = 1'b1;
		return r;
	endfunction : pw_end_dir

	always_comb
	begin
		wipers_next = wipers_reg;
		dir_next = dir_reg;
		bal_seen_next = bal_seen_reg;
		bal_ref_next = bal_ref_reg;
		wipers_next.pos0 = pw_move(pos0, ch0_up, ch0_dn);
		wipers_next.pos1 = pw_move(pos1, ch1_up, ch1_dn);
		if (vol_up && vol_up_ok)
		begin
			wipers_next.pos0 = pos0 - 1'b1;
			wipers_next.pos1 = pos1 - 1'b1;
		end
		else if (vol_dn && vol_dn_ok)
		begin
			wipers_next.pos0 = pos0 + 1'b1;
			wipers_next.pos1 = pos1 + 1'b1;
		end
		if (vol_up || vol_dn)
			bal_seen_next = 1'b0;
		if ((bal0 || bal1) && !bal_seen_reg)
		begin
			bal_seen_next = 1'b1;
			bal_ref_next = nearer_high;
		end
		if (bal0 && !both_low)
		begin
			if (pos0 > pos1 && pos0 > bal_ref_next)
				wipers_next.pos0 = pos0 - 1'b1;
			else if (pos0 <= pos1 && pos1 < POS_LOW)
				wipers_next.pos1 = pos1 + 1'b1;
		end
		if (bal1 && !both_low)
		begin
			if (pos1 > pos0 && pos1 > bal_ref_next)
				wipers_next.pos1 = pos1 - 1'b1;
			else if (pos1 <= pos0 && pos0 < POS_LOW)
				wipers_next.pos0 = pos0 + 1'b1;
		end
		if (single_mode_reg)
		begin
			if (indep)
			begin
				dir_next[0] = pw_end_dir(wipers_next.pos0, dir_reg[0]);
				dir_next[1] = pw_end_dir(wipers_next.pos1, dir_reg[1]);
			end
			else if (vol_up || vol_dn)
				dir_next[0] = pw_end_dir(wipers_next.pos0, pw_end_dir(wipers_next.pos1, dir_reg[0]));
			if (idle_pin0 && active)
				dir_next[0] = !dir_reg[0];
			if (idle_pin2 && active)
				dir_next[1] = !dir_reg[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wipers_reg <= '{pos1: POS_LOW, pos0: POS_LOW};
			dir_reg <= 2'h3;
			bal_seen_reg <= 1'b0;
			bal_ref_reg <= POS_LOW;
		end
		else
		begin
			wipers_reg <= wipers_next;
			dir_reg <= dir_next;
			bal_seen_reg <= bal_seen_next;
			bal_ref_reg <= bal_ref_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_powerup_hold: assert property (!contacts_active_reg |-> (pos0 == POS_LOW && pos1 == POS_LOW))
		else $error("wiper moved before contacts were active");
	a_pos_in_range: assert property (pos0 <= POS_MUTE && pos1 <= POS_MUTE)
		else $error("wiper position out of range");
	a_ignore_early: assert property (!contacts_active_reg |=> $stable(wipers_reg))
		else $error("contact acted during power-up hold-off");
	a_indep_split: assert property ((indep && !up_contact_ch_one && !down_contact_ch_one) |=> $stable(pos1))
		else $error("channel-0 contact moved wiper 1");
	a_up_decrease: assert property ((indep && !single_mode_reg && up_contact_ch_zero && !down_contact_ch_zero
		&& pos0 != POS_HIGH_END) |=> pos0 == $past(pos0) - 1'b1)
		else $error("up contact did not lower position by one");
	a_vol_offset: assert property ((stereo && !bal0 && !bal1) |=> ($past(pos0) - $past(pos1)) == (pos0 - pos1))
		else $error("volume move changed the offset");
	a_bal_bottom: assert property ((stereo && both_low && !vol_up && !vol_dn) |=> $stable(wipers_reg))
		else $error("balance moved wipers off the bottom");
	a_bal_zero_up: assert property ((bal0 && pos0 > pos1 && bal_seen_reg && pos0 > bal_ref_reg)
		|=> (pos0 == $past(pos0) - 1'b1) && $stable(pos1))
		else $error("balance-0 did not raise wiper 0");
	a_dual_end_hold: assert property ((indep && !single_mode_reg && pos0 == POS_HIGH_END && !down_contact_ch_zero)
		|=> pos0 == POS_HIGH_END)
		else $error("wiper left its end without opposite input");
	// Serial readiness is absolute time, so it must not lag its cycle budget
	a_serial_ready: assert property (!serial_ready_reg |-> int'(ready_cnt_reg) < SERIAL_READY_CYCLES)
		else $error("serial ready came too late");

endmodule : pw_wiper_ctrl

// ===== pkg/pw_pkg.sv
// Shared constants and types for the pushbutton wiper control block
package pw_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and time base
	localparam int CLK_MHZ = 200;
	localparam int US_PER_MS = 1000;
	localparam int CYCLES_PER_MS = CLK_MHZ * US_PER_MS;
	localparam int SERIAL_READY_NS = 10_000;
	// Longest time, so round down
	localparam int SERIAL_READY_CYCLES = (SERIAL_READY_NS * CLK_MHZ) / 1000;

	////////////////////////////////////////////////////////////////////////////
	// Contact timing, counted in 1 ms ticks
	localparam int POWERUP_MS = 50;
	localparam int PULSE_MIN_MS = 1;
	localparam int GAP_MIN_MS = 1;
	localparam int HOLD_MS = 1000;
	localparam int REPEAT_MS = 100;
	localparam int REVERSE_MS = 1000;
	localparam int MS_CNT_W = 11;

	////////////////////////////////////////////////////////////////////////////
	// Wiper positions
	localparam int POS_W = 7;
	typedef logic [POS_W-1:0] pw_pos_t;
	localparam pw_pos_t POS_HIGH_END = 7'h00;
	localparam pw_pos_t POS_LOW = 7'h3F;
	localparam pw_pos_t POS_MUTE = 7'h40;

	////////////////////////////////////////////////////////////////////////////
	// Physical contact pins, shared between independent and stereo use
	localparam int NUM_PINS = 4;
	localparam int PIN_UP0_RAISE = 0;
	localparam int PIN_DN0_LOWER = 1;
	localparam int PIN_UP1_BAL0 = 2;
	localparam int PIN_DN1_BAL1 = 3;

	typedef struct packed {
		logic step;
		logic idle;
		logic pressed;
	} pw_contact_ev_s;

	typedef struct packed {
		pw_pos_t pos1;
		pw_pos_t pos0;
	} pw_wipers_s;

	typedef enum logic {PW_POWERUP, PW_ACTIVE} pw_phase_e;

endpackage : pw_pkg

// ===== tb/pw_button_model.sv
// Pushbutton model that bounces its contacts on every press and release
`timescale 1ns/1ps
module pw_button_model #(
	parameter int BOUNCE_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic [pw_pkg::NUM_PINS-1:0] press,
	output logic [pw_pkg::NUM_PINS-1:0] contact_b
);
	import pw_pkg::*;
	logic [NUM_PINS-1:0] press_q = '0;
	logic [NUM_PINS-1:0] chatter = '0;
	int bounce_cnt [NUM_PINS];
	initial foreach (bounce_cnt[i]) bounce_cnt[i] = 0;
	////////////////////////////////////////////////////////////////////////////
	// bounce shorter than a tick
	always @(posedge clk_sys)
	begin
		foreach (bounce_cnt[i])
		begin
			if (press[i] !== press_q[i])
				bounce_cnt[i] <= BOUNCE_CYCLES;
			else if (bounce_cnt[i] > 0)
				bounce_cnt[i] <= bounce_cnt[i] - 1;
		end
		press_q <= press;
		chatter <= ~chatter;
	end
	// pressed pulls low, released sits at the pull-up level
	always_comb
		foreach (contact_b[i])
			contact_b[i] = (bounce_cnt[i] > 0) ? chatter[i] : ~press[i];
endmodule : pw_button_model

// ===== tb/test_pw_wiper_ctrl.sv
// Self-checking bench for the pushbutton wiper control block
`timescale 1ns/1ps
module test_pw_wiper_ctrl;
	import pw_pkg::*;
	// Ten cycles a millisecond keeps the one-second holds affordable
	localparam int CPM = 10;
	logic clk_sys;
	logic rst_b = 1'b0;
	logic [NUM_PINS-1:0] press = '0;
	logic [NUM_PINS-1:0] contact_b;
	logic mode_independent = 1'b1;
	logic single_button_sel = 1'b0;
	pw_wipers_s wipers_reg;
	logic serial_ready_reg;
	logic contacts_active_reg;
	logic stereo_mode_reg;
	logic single_mode_reg;
	int errors = 0;
	int tests_run = 0;
	int p0;
	int p1;
	int dir0;
	logic [31:0] lfsr = 32'hCCCEA64C;

	pw_wiper_ctrl #(.CYCLES_PER_MS(CPM)) pw_wiper_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.contact_b(contact_b), .mode_independent(mode_independent), .single_button_sel(single_button_sel),
		.wipers_reg(wipers_reg), .serial_ready_reg(serial_ready_reg), .contacts_active_reg(contacts_active_reg),
		.stereo_mode_reg(stereo_mode_reg), .single_mode_reg(single_mode_reg));
	pw_button_model pw_button_model_i (.clk_sys(clk_sys), .press(press), .contact_b(contact_b));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic check(input logic [POS_W-1:0] seen, input logic [POS_W-1:0] exp);
		// Look after the edge's updates have settled
		#1;
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: saw %0d expected %0d", $time, seen, exp);
		end
	endtask : check

	task automatic check_wipers();
		check(wipers_reg.pos0, POS_W'(p0));
		check(wipers_reg.pos1, POS_W'(p1));
	endtask : check_wipers

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	task automatic model_step(input int pin);
		if (single_button_sel)
		begin
			p0 += dir0;
			if (p0 == 0 || p0 == 64)
				dir0 = -dir0;
		end
		else if (mode_independent)
			case (pin)
				0: if (p0 > 0) p0--;
				1: if (p0 < 64) p0++;
				2: if (p1 > 0) p1--;
				default: if (p1 < 64) p1++;
			endcase
		else
			case (pin)
				0: if (p0 > 0 && p1 > 0) begin p0--; p1--; end
				1: if (p0 < 64 && p1 < 64) begin p0++; p1++; end
				2: if (p0 > p1) p0--; else if (p1 < 63) p1++;
				default: if (p1 > p0) p1--; else if (p0 < 63) p0++;
			endcase
	endtask : model_step

	task automatic drive(input int pin, input logic val, input int cycles);
		@(posedge clk_sys);
		press[pin] <= val;
		repeat (cycles - 1) @(posedge clk_sys);
	endtask : drive

	// One closure, a 5 ms release, then compare against the model
	task automatic press_for(input int pin, input int hold_ms);
		int n;
		n = (hold_ms < 3) ? 0 : 1 + ((hold_ms > 1002) ? (hold_ms - 1002) / 100 + 1 : 0);
		repeat (n) model_step(pin);
		drive(pin, 1'b1, hold_ms * CPM);
		drive(pin, 1'b0, 5 * CPM);
		check_wipers();
	endtask : press_for

	task automatic do_reset(input logic indep, input logic single);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		// straps change only while reset is low, then hold until the next reset
		mode_independent <= indep;
		single_button_sel <= single;
		press <= '0;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		p0 = 63;
		p1 = 63;
		dir0 = -1;
		drive(0, 1'b1, 200);
		drive(0, 1'b0, 250);
		check(POS_W'(contacts_active_reg), 7'h00);
		repeat (100) @(posedge clk_sys);
		check(POS_W'(contacts_active_reg), 7'h01);
		check_wipers();
		check(POS_W'(stereo_mode_reg), POS_W'(!indep));
		check(POS_W'(single_mode_reg), POS_W'(single));
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		end_sim();
	end

	initial
	begin
		do_reset(1'b1, 1'b0);
		repeat (1440) @(posedge clk_sys);
		check(POS_W'(serial_ready_reg), 7'h00);
		repeat (15) @(posedge clk_sys);
		check(POS_W'(serial_ready_reg), 7'h01);
		press_for(1, 5);
		press_for(1, 5);
		press_for(0, 5);
		press_for(3, 5);
		drive(0, 1'b1, 5);
		drive(0, 1'b0, 5 * CPM);
		check_wipers();
		model_step(0);
		drive(0, 1'b1, 5 * CPM);
		drive(0, 1'b0, 3);
		drive(0, 1'b1, 5 * CPM);
		drive(0, 1'b0, 5 * CPM);
		check_wipers();
		press_for(2, 1350);
		repeat (12)
		begin
			lfsr = lfsr_next(lfsr);
			press_for(int'(lfsr[1:0]), 3 + int'(lfsr[12:8]) % 20);
		end
		do_reset(1'b0, 1'b0);
		press_for(2, 5);
		press_for(0, 5);
		press_for(0, 5);
		press_for(0, 5);
		press_for(3, 5);
		press_for(3, 5);
		press_for(2, 5);
		press_for(2, 5);
		press_for(2, 5);
		press_for(0, 1350);
		press_for(1, 1950);
		do_reset(1'b1, 1'b1);
		repeat (3) press_for(0, 5);
		drive(0, 1'b0, 1100 * CPM);
		dir0 = -dir0;
		press_for(0, 5);
		repeat (3) press_for(0, 5);
		press_for(0, 5);
		end_sim();
	end
endmodule : test_pw_wiper_ctrl
